// File: logic/rtcx_pkg.sv
/*
  Shared constants for the calendar-clock housekeeping block: register
  addresses, field positions, load values and timebase counts.
  Assumes a byte-wide register port with a 4-bit address.
*/
package rtcx_pkg;

  typedef logic [7:0] rtcx_byte_t;
  typedef logic [3:0] rtcx_addr_t;

  // Register addresses
  localparam rtcx_addr_t A_YEAR   = 4'h0;
  localparam rtcx_addr_t A_MONTH  = 4'h1;
  localparam rtcx_addr_t A_DAY    = 4'h2;
  localparam rtcx_addr_t A_WDAY   = 4'h3;
  localparam rtcx_addr_t A_HOUR   = 4'h4;
  localparam rtcx_addr_t A_MIN    = 4'h5;
  localparam rtcx_addr_t A_SEC    = 4'h6;
  localparam rtcx_addr_t A_ST1    = 4'h7;
  localparam rtcx_addr_t A_ST2    = 4'h8;
  localparam rtcx_addr_t A_OFS    = 4'h9;
  localparam rtcx_addr_t A_ALM2   = 4'ha;
  localparam rtcx_addr_t A_CORR   = 4'hb;
  localparam rtcx_addr_t A_FREE   = 4'hc;
  localparam rtcx_addr_t A_IRQST  = 4'hd;
  localparam rtcx_addr_t A_IRQMSK = 4'he;

  // Storage indices
  localparam int CAL_N    = 7;
  localparam int AUX_N    = 5;
  localparam int AUX_ST2  = 0;
  localparam int AUX_OFS  = 1;

  // Load values
  localparam rtcx_byte_t BYTE_ZERO = 8'h00;
  localparam rtcx_byte_t CAL_ONE   = 8'h01;
  localparam rtcx_byte_t RST_ST2   = 8'h01;
  localparam rtcx_byte_t RST_OFS   = 8'h80;
  localparam logic [2:0] RST_ST1_USER = 3'h0;
  localparam logic [1:0] RST_IRQ_ST  = 2'h1;
  localparam logic [1:0] RST_IRQ_MSK = 2'h0;

  // Field positions
  localparam int ST1_RESET_BIT = 7;
  localparam int ST2_FREQ_BIT  = 7;
  localparam int ST2_MIN_BIT   = 6;
  localparam int ST2_32K_BIT   = 4;
  localparam int OFS_SEL_HI    = 7;
  localparam int OFS_SEL_N     = 5;

  // Timebase
  localparam int TB_HZ               = 32768;
  localparam int SAMPLE_WIN_TENTH_MS = 156;
  localparam logic [8:0] SAMPLE_WIN_TICKS = 9'((SAMPLE_WIN_TENTH_MS * TB_HZ) / 10000);

  typedef enum logic [1:0] {
    RTCX_LS_WAIT,
    RTCX_LS_SAMPLE,
    RTCX_LS_HELD
  } rtcx_ls_state_e;

endpackage

// File: logic/rtcx_lsd_if.sv
/*
  Link between the register side and the low-supply sampler.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ns
interface rtcx_lsd_if;
  logic tbTick;
  logic secStart;
  logic clearReq;
  logic supplyLow;
  logic flag;
  logic setPulse;

  modport ctrl (output tbTick, output secStart, output clearReq, output supplyLow,
                input flag, input setPulse);
  modport det  (input tbTick, input secStart, input clearReq, input supplyLow,
                output flag, output setPulse);
endinterface

// File: logic/rtcx_low_supply.sv
/*
  Once-per-second low-supply sampler with a sticky flag.
  Assumes tbTick and secStart are one-cycle pulses on ref_clk and
  supplyLow is already synchronised.
*/
`timescale 1ns/1ns
module rtcx_low_supply
  import rtcx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  rtcx_lsd_if.det  lsd
);
  import rtcx_pkg::*;

  rtcx_ls_state_e state_reg;
  logic [8:0]     winCnt_reg;
  logic           setNow;
  logic           flag_reg;
  logic           setPulse_reg;

  // Set beats a simultaneous clear
  assign setNow = (state_reg == RTCX_LS_SAMPLE) && lsd.supplyLow;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= RTCX_LS_WAIT;
    end else if (setNow) begin
      state_reg <= RTCX_LS_HELD;
    end else if (lsd.clearReq) begin
      state_reg <= RTCX_LS_WAIT;
    end else begin
      case (state_reg)
        RTCX_LS_WAIT:
          if (lsd.secStart) begin
            state_reg <= RTCX_LS_SAMPLE;
          end
        RTCX_LS_SAMPLE:
          if (lsd.tbTick && winCnt_reg == SAMPLE_WIN_TICKS - 9'h001) begin
            state_reg <= RTCX_LS_WAIT;
          end
        RTCX_LS_HELD: state_reg <= RTCX_LS_HELD;
        default:      state_reg <= RTCX_LS_WAIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_reg != RTCX_LS_SAMPLE) begin
      winCnt_reg <= 9'h000;
    end else if (lsd.tbTick) begin
      winCnt_reg <= winCnt_reg + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_reg     <= 1'b0;
      setPulse_reg <= 1'b0;
    end else begin
      flag_reg     <= setNow | (flag_reg & ~lsd.clearReq);
      setPulse_reg <= setNow;
    end
  end

  assign lsd.flag     = flag_reg;
  assign lsd.setPulse = setPulse_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_sample_window: assert property (
    state_reg == RTCX_LS_SAMPLE |-> winCnt_reg < SAMPLE_WIN_TICKS)
    else $error("sampling window overran");

  a_flag_sticky: assert property (
    lsd.flag && !lsd.clearReq |=> lsd.flag && state_reg == RTCX_LS_HELD)
    else $error("low-supply flag or hold lost");

  a_low_sets_flag: assert property (
    state_reg == RTCX_LS_SAMPLE && lsd.supplyLow |=> lsd.flag && lsd.setPulse)
    else $error("low sample did not set flag");

  a_clear_restart: assert property (
    lsd.clearReq && state_reg != RTCX_LS_SAMPLE |=> !lsd.flag && state_reg == RTCX_LS_WAIT)
    else $error("clear did not restart sampling");

endmodule // rtcx_low_supply

// File: logic/rtcx_aux_regs.sv
/*
  Register-side housekeeping of a low-power calendar clock: load values
  at power-on and software init, status flags, frequency output data,
  correction and free bytes, low-supply sampling and an interrupt line.
  Assumes rst_n is the power-on detect, timebaseClk is the 32.768 kHz
  timebase arriving from outside ref_clk, and an external open-drain pad.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Selected frequency bits ANDed onto interrupt pin
// - Low three frequency-register bits are plain storage
// - Correction byte read/write, reversed; zero disables
// - Free byte holds last write, reversed order
// - Calendar loads 00-01-01, weekday 0, 00:00:00
// - Power-on loads status 01h, frequency 80h, interrupt status 01h, others 0
// - Power-on sets flag, 1 Hz on pin
// - Init clears power-on flag, leaves frequency mode
// - Init keeps status1 bits 6-4, clears others
// - Supply sampled once per second, 15.6 ms
// - Low sample sets sticky flag, stops sampling
// - Flag read or init clears, restarts sampling
// - Reset bit write initialises, reads zero
// - Power-on flag bit 0, low-supply bit 1
module rtcx_aux_regs
  import rtcx_pkg::*;
#(
  parameter int TICKS_PER_SEC = TB_HZ
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire rtcx_pkg::rtcx_addr_t regAddr,
  input  wire rtcx_pkg::rtcx_byte_t regWrData,
  input  wire logic             regWrEn,
  input  wire logic             regRdEn,
  output rtcx_pkg::rtcx_byte_t  regRdData,
  input  wire logic             timebaseClk,
  input  wire logic             supplyLowPin,
  output logic                  intPinOut,
  output logic                  intPinOe,
  output logic                  irq
);
  import rtcx_pkg::*;

  localparam int SEC_W = $clog2(TICKS_PER_SEC);

  rtcx_lsd_if lsd ();

  logic             tbMeta;
  logic             tbSync;
  logic             tbPrev;
  logic             supMeta;
  logic             supSync;
  logic             tick;
  logic [SEC_W-1:0] subCnt_reg;
  rtcx_byte_t       calReg [CAL_N];
  rtcx_byte_t       auxReg [AUX_N];
  logic [2:0]       st1User_reg;
  logic             powerOnFlag_reg;
  logic             freqMode_reg;
  logic [1:0]       irqStatus_reg;
  logic [1:0]       irqMask_reg;
  logic             swInit;
  logic             st1Read;
  logic [2:0]       auxSel;
  logic             auxHit;
  logic [OFS_SEL_N-1:0] freqWave;
  logic [OFS_SEL_N-1:0] freqSel;
  logic             andOut;
  logic             freqMode;
  rtcx_byte_t       rdNext;

  function automatic rtcx_byte_t calInit(input int idx);
    calInit = (idx == int'(A_MONTH) || idx == int'(A_DAY)) ? CAL_ONE : BYTE_ZERO;
  endfunction

  function automatic rtcx_byte_t auxPor(input int idx);
    auxPor = (idx == AUX_ST2) ? RST_ST2 : ((idx == AUX_OFS) ? RST_OFS : BYTE_ZERO);
  endfunction

  // Pins cross into ref_clk; the first stage is never looked at
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tbMeta  <= 1'b0;
      tbSync  <= 1'b0;
      tbPrev  <= 1'b0;
      supMeta <= 1'b0;
      supSync <= 1'b0;
    end else begin
      tbMeta  <= timebaseClk;
      tbSync  <= tbMeta;
      tbPrev  <= tbSync;
      supMeta <= supplyLowPin;
      supSync <= supMeta;
    end
  end

  assign tick = tbSync & ~tbPrev;

  // Seconds divider on timebase edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n || swInit) begin
      subCnt_reg <= '0;
    end else if (tick) begin
      if (subCnt_reg == SEC_W'(TICKS_PER_SEC - 1)) begin
        subCnt_reg <= '0;
      end else begin
        subCnt_reg <= subCnt_reg + SEC_W'(1);
      end
    end
  end

  assign swInit  = regWrEn && regAddr == A_ST1 && regWrData[ST1_RESET_BIT];
  assign st1Read = regRdEn && regAddr == A_ST1;
  assign auxSel  = 3'(regAddr - A_ST2);
  assign auxHit  = regAddr >= A_ST2 && regAddr <= A_FREE;

  assign lsd.tbTick    = tick;
  assign lsd.secStart  = tick && subCnt_reg == SEC_W'(TICKS_PER_SEC - 1);
  assign lsd.clearReq  = swInit || st1Read;
  assign lsd.supplyLow = supSync;

  rtcx_low_supply u_low_supply (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .lsd     (lsd)
  );

  // Calendar bytes; counting lives elsewhere
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CAL_N; i++) begin
      if (!rst_n || swInit) begin
        calReg[i] <= calInit(i);
      end else if (regWrEn && int'(regAddr) == i) begin
        calReg[i] <= regWrData;
      end
    end
  end

  // Status2, frequency data, alarm 2, correction, free: one load point
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < AUX_N; i++) begin
      if (!rst_n) begin
        auxReg[i] <= auxPor(i);
      end else if (swInit) begin
        auxReg[i] <= BYTE_ZERO;
      end else if (regWrEn && auxHit && int'(auxSel) == i) begin
        // Low frequency bits, correction and free bytes are stored as is
        auxReg[i] <= regWrData;
      end
    end
  end

  // Hour mode and user bits survive init
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st1User_reg <= RST_ST1_USER;
    end else if (regWrEn && regAddr == A_ST1 && !swInit) begin
      st1User_reg <= regWrData[6:4];
    end
  end

  // Power-on flag: set only by power-on, so no set/clear race
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      powerOnFlag_reg <= 1'b1;
    end else if (swInit || st1Read) begin
      powerOnFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      freqMode_reg <= 1'b1;
    end else if (swInit) begin
      freqMode_reg <= 1'b0;
    end
  end

  // Frequency outputs: bit 7 is the slowest wave, 1 Hz
  genvar k;
  generate
    for (k = 0; k < OFS_SEL_N; k++) begin : g_wave
      assign freqWave[k] = subCnt_reg[SEC_W-1-k];
      assign freqSel[k]  = auxReg[AUX_OFS][OFS_SEL_HI-k];
    end
  endgenerate

  assign andOut   = (|freqSel) && (&(freqWave | ~freqSel));
  assign freqMode = freqMode_reg || (auxReg[AUX_ST2][ST2_FREQ_BIT]
                    && !auxReg[AUX_ST2][ST2_MIN_BIT] && !auxReg[AUX_ST2][ST2_32K_BIT]);

  // Open-drain pad: only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      intPinOut <= 1'b0;
      intPinOe  <= 1'b0;
    end else begin
      intPinOut <= 1'b0;
      intPinOe  <= freqMode && andOut;
    end
  end

  // Events stick; read clears, a new event in that cycle still lands
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqStatus_reg <= RST_IRQ_ST;
    end else begin
      irqStatus_reg <= ((regRdEn && regAddr == A_IRQST) ? 2'h0 : irqStatus_reg)
                       | {lsd.setPulse, 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqMask_reg <= RST_IRQ_MSK;
    end else if (regWrEn && regAddr == A_IRQMSK) begin
      irqMask_reg <= regWrData[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  always_comb begin
    rdNext = BYTE_ZERO;
    if (regAddr <= A_SEC) begin
      rdNext = calReg[regAddr[2:0]];
    end else if (regAddr == A_ST1) begin
      rdNext = {1'b0, st1User_reg, 2'h0, lsd.flag, powerOnFlag_reg};
    end else if (auxHit) begin
      rdNext = auxReg[auxSel];
    end else if (regAddr == A_IRQST) begin
      rdNext = {6'h00, irqStatus_reg};
    end else if (regAddr == A_IRQMSK) begin
      rdNext = {6'h00, irqMask_reg};
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdData <= BYTE_ZERO;
    end else begin
      regRdData <= regRdEn ? rdNext : BYTE_ZERO;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_por_load: assert property (disable iff (1'b0)
    $rose(rst_n) |-> auxReg[AUX_ST2] == RST_ST2 && auxReg[AUX_OFS] == RST_OFS
      && auxReg[2] == BYTE_ZERO && auxReg[3] == BYTE_ZERO && auxReg[4] == BYTE_ZERO)
    else $error("power-on load values wrong");

  a_por_mode: assert property (disable iff (1'b0)
    $rose(rst_n) |-> powerOnFlag_reg && freqMode_reg && !lsd.flag)
    else $error("power-on flag or frequency mode missing");

  a_cal_load: assert property (
    swInit |=> calReg[0] == 8'h00 && calReg[1] == 8'h01 && calReg[2] == 8'h01
      && calReg[3] == 8'h00 && calReg[4] == 8'h00 && calReg[5] == 8'h00
      && calReg[6] == 8'h00)
    else $error("calendar init load wrong");

  // Pin is registered, so the init edge may still launch one last pulse
  a_init_mode: assert property (
    swInit |=> !powerOnFlag_reg && !freqMode_reg ##1 !intPinOe)
    else $error("init left power-on state");

  a_init_clear: assert property (
    swInit |=> st1User_reg == $past(st1User_reg) && auxReg[AUX_OFS] == 8'h00
      && auxReg[AUX_ST2] == 8'h00 && auxReg[2] == 8'h00 && auxReg[3] == 8'h00
      && auxReg[4] == 8'h00)
    else $error("init register values wrong");

  a_init_atomic: assert property (
    swInit ##[1:4] (regRdEn && regAddr == A_ST1) |=> regRdData[1:0] == 2'h0)
    else $error("read saw partial init");

  a_byte_store: assert property (
    regWrEn && regAddr == A_FREE && !swInit ##1 !regWrEn ##1 regRdEn && regAddr == A_FREE
      |=> regRdData == $past(regWrData, 3))
    else $error("free byte lost its value");

  a_reset_reads_zero: assert property (
    regRdEn && regAddr == A_ST1 |=> !regRdData[7])
    else $error("reset bit read as one");

  a_flags_ro: assert property (
    regRdEn && regAddr == A_ST1 |=> regRdData[1:0] == $past({lsd.flag, powerOnFlag_reg}))
    else $error("flag bits misplaced");

  a_user_bits_inert: assert property (
    freqMode && freqSel == 5'h00 |=> !intPinOe)
    else $error("low frequency bits drove the pin");

  a_freq_and: assert property (
    freqMode && andOut |=> intPinOe)
    else $error("selected frequencies not on pin");

endmodule // rtcx_aux_regs

// File: verif/rtcx_host_model.sv
/*
  Host model: single-byte register cycles on the plain register port.
  Assumes the block never stalls and read data stand one cycle.
*/
`timescale 1ns/1ns
module rtcx_host_model
  import rtcx_pkg::*;
(
  input  wire logic                 ref_clk,
  output rtcx_pkg::rtcx_addr_t      regAddr,
  output rtcx_pkg::rtcx_byte_t      regWrData,
  output logic                      regWrEn,
  output logic                      regRdEn,
  input  wire rtcx_pkg::rtcx_byte_t regRdData
);
  import rtcx_pkg::*;

  initial begin
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  task automatic wr(input rtcx_addr_t a, input rtcx_byte_t d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge ref_clk);
    regWrEn   <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input rtcx_addr_t a, output rtcx_byte_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    // Taken at the edge that closes their only cycle
    @(posedge ref_clk);
    d = regRdData;
  endtask

  // 24-hour alarm hour: BCD, bits reversed, AM/PM set to match, hour enable
  task automatic alarm_hour_24(input int h);
    logic [5:0] bcd;
    bcd = {2'(h / 10), 4'(h % 10)};
    wr(A_OFS, {bcd[0], bcd[1], bcd[2], bcd[3], bcd[4], bcd[5], h >= 12, 1'b1});
  endtask

  // Detector still busy right after power-on
  task automatic power_up_wait(input int cyc);
    repeat (cyc) @(posedge ref_clk);
  endtask

  // Correction unused: zero it
  task automatic corr_off();
    wr(A_CORR, BYTE_ZERO);
  endtask

  // Any flag seen set means state is suspect
  task automatic check_and_init(output rtcx_byte_t st);
    rd(A_ST1, st);
    if (st[1:0] != 2'h0) begin
      wr(A_ST1, 8'h80);
    end
  endtask
endmodule  // rtcx_host_model

// File: verif/testbench.sv
/*
  Self-checking bench for the housekeeping register block.
  Assumes a shortened second of 64 timebase ticks and the host model.
*/
`timescale 1ns/1ns
module testbench;
  import rtcx_pkg::*;

  localparam int TPS     = 64;
  localparam int SEC_CYC = TPS * 8;
  localparam rtcx_byte_t POR_VAL [16] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  localparam rtcx_byte_t INIT_VAL [13] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h70, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  logic       ref_clk      = 1'b0;
  logic       rst_n        = 1'b0;
  logic       timebaseClk  = 1'b0;
  logic       supplyLowPin = 1'b0;
  rtcx_addr_t regAddr;
  rtcx_byte_t regWrData;
  rtcx_byte_t regRdData;
  logic       regWrEn;
  logic       regRdEn;
  logic       intPinOut;
  logic       intPinOe;
  logic       irq;
  int         nFail        = 0;
  int         checksDone   = 0;
  int         cycles       = 0;
  rtcx_byte_t v;

  always #25 ref_clk = ~ref_clk;
  // Free-running timebase, eight ref_clk periods, edges on ref_clk falling edges
  always #200 timebaseClk = ~timebaseClk;

  rtcx_aux_regs #(.TICKS_PER_SEC(TPS)) rtcx_aux_regs_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .timebaseClk(timebaseClk), .supplyLowPin(supplyLowPin),
    .intPinOut(intPinOut), .intPinOe(intPinOe), .irq(irq));

  rtcx_host_model rtcx_host_model_inst (
    .ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

  task automatic final_report();
    if (nFail == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input rtcx_byte_t got, input rtcx_byte_t exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input rtcx_addr_t a, input rtcx_byte_t exp);
    rtcx_host_model_inst.rd(a, v);
    chk(v, exp);
  endtask

  function automatic rtcx_byte_t inRange(input int n, input int lo, input int hi);
    return (n >= lo && n <= hi) ? 8'h01 : 8'h00;
  endfunction

  // Two whole seconds, after the registered pin settles
  task automatic pinHigh(output int n);
    n = 0;
    repeat (4) @(negedge ref_clk);
    repeat (2 * SEC_CYC) begin
      @(negedge ref_clk);
      if (intPinOe === 1'b1) n++;
    end
  endtask

  task automatic waitIrq(input int bound, input logic e);
    for (int i = 0; i < bound && irq !== e; i++) @(negedge ref_clk);
    chk({7'h0, irq}, {7'h0, e});
  endtask

  task automatic t_power_on();
    int n;
    pinHigh(n);
    chk(inRange(n, SEC_CYC - 24, SEC_CYC + 24), 8'h01);
    chk({7'h0, intPinOut}, 8'h00);
    for (int a = 0; a < 16; a++) rdChk(4'(a), POR_VAL[a]);
    rdChk(A_ST1, 8'h00);
  endtask

  task automatic t_storage();
    int n;
    rtcx_host_model_inst.wr(A_CORR, 8'ha5);
    rdChk(A_CORR, 8'ha5);
    rtcx_host_model_inst.wr(A_FREE, 8'h3c);
    rdChk(A_FREE, 8'h3c);
    rtcx_host_model_inst.wr(A_ST1, 8'h7f);
    rdChk(A_ST1, 8'h70);
    rtcx_host_model_inst.alarm_hour_24(19);
    rdChk(A_OFS, 8'h9b);
    rtcx_host_model_inst.wr(4'hf, 8'hff);
    rdChk(4'hf, 8'h00);
    rtcx_host_model_inst.wr(A_OFS, 8'h07);
    rdChk(A_OFS, 8'h07);
    pinHigh(n);
    chk(inRange(n, 0, 0), 8'h01);
    rtcx_host_model_inst.wr(A_OFS, 8'hc0);
    pinHigh(n);
    chk(inRange(n, SEC_CYC / 2 - 24, SEC_CYC / 2 + 24), 8'h01);
    rtcx_host_model_inst.corr_off();
    rdChk(A_CORR, 8'h00);
  endtask

  task automatic t_init();
    int n;
    rtcx_host_model_inst.wr(A_YEAR, 8'h55);
    rtcx_host_model_inst.wr(A_SEC, 8'h59);
    rtcx_host_model_inst.wr(A_ST2, 8'h12);
    rtcx_host_model_inst.wr(A_ALM2, 8'h11);
    rtcx_host_model_inst.wr(A_CORR, 8'ha5);
    rtcx_host_model_inst.wr(A_FREE, 8'h3c);
    rtcx_host_model_inst.wr(A_ST1, 8'h80);
    for (int a = 0; a < 13; a++) rdChk(4'(a), INIT_VAL[a]);
    rtcx_host_model_inst.wr(A_OFS, 8'h80);
    pinHigh(n);
    chk(inRange(n, 0, 0), 8'h01);
  endtask

  task automatic t_low_supply();
    rtcx_host_model_inst.wr(A_IRQMSK, 8'h00);
    supplyLowPin <= 1'b1;
    repeat (2 * SEC_CYC + 100) @(posedge ref_clk);
    chk({7'h0, irq}, 8'h00);
    rtcx_host_model_inst.wr(A_IRQMSK, 8'h02);
    waitIrq(8, 1'b1);
    rdChk(A_IRQST, 8'h02);
    waitIrq(4, 1'b0);
    @(posedge ref_clk);
    supplyLowPin <= 1'b0;
    repeat (SEC_CYC) @(posedge ref_clk);
    rdChk(A_ST1, 8'h72);
    rdChk(A_ST1, 8'h70);
    supplyLowPin <= 1'b1;
    waitIrq(2 * SEC_CYC + 50, 1'b1);
    @(posedge ref_clk);
    supplyLowPin <= 1'b0;
    rtcx_host_model_inst.check_and_init(v);
    chk(v, 8'h72);
    rdChk(A_ST1, 8'h70);
  endtask

  // Whole run needs about 6500 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nFail++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rtcx_host_model_inst.power_up_wait(SEC_CYC / 2);
    t_power_on();
    t_storage();
    t_init();
    t_low_supply();
    final_report();
  end
endmodule  // testbench
